// >>> asr4k_ctrl.v
// Host controller driving a 4096 by 4 asynchronous static memory.
`timescale 1ns/1ps
`include "asr4k_defines.vh"

// Summary of operation
// - The first of select or strobe to rise ends the write.
// - Data setup and hold are measured from that terminating rising edge.
// - Write address stable 15 ns before write end, 0 ns after.
// - Write address presented at least 0 ns before write start.
// - Write data valid 10 ns before write end, held 0 ns after.
// - Strobe low 15 ns, select low 15 ns to end, writes 20 ns apart.
module asr4k_ctrl #(
  parameter ADDR_W = `ASR4K_ADDR_W,
  parameter DATA_W = `ASR4K_DATA_W
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // User request
  input wire req_valid,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  output wire req_ready,
  // User read answer
  output reg rd_valid,
  output reg [DATA_W-1:0] rd_data,
  // Memory pins
  output reg [ADDR_W-1:0] addr_line,
  output reg chip_sel_n,
  output reg wr_strobe_n,
  input wire [DATA_W-1:0] data_line_in,
  output reg [DATA_W-1:0] data_line_out,
  output reg data_line_oe_n
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD_WAIT = 3'h1;
  localparam [2:0] ST_WR_SETUP = 3'h2;
  localparam [2:0] ST_WR_PULSE = 3'h3;
  localparam [2:0] ST_WR_RECOV = 3'h4;

  // ----------------------------------------
  // Phase lengths
  // ----------------------------------------
  // A load of N keeps its phase for N + 1 cycles, because the phase ends in
  // the cycle in which the counter reads zero; the strobe and recovery loads allow for it, the read load does not.
  localparam CNT_W = 4;
  localparam integer RD_LOAD = `ASR4K_READ_WAIT_CYC;
  localparam integer STROBE_LOAD = `ASR4K_STROBE_CYC - 1;
  localparam integer RECOV_LOAD = `ASR4K_WRITE_CYC - `ASR4K_STROBE_CYC - 1;

  // Cuts a cycle count to the counter width; a count above the width wraps.
  function [CNT_W-1:0] fn_cnt;
    input integer cyc;
    begin
      fn_cnt = cyc[CNT_W-1:0];
    end
  endfunction

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg cnt_load;
  reg [CNT_W-1:0] cnt_val;
  wire cnt_done;

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  asr4k_wait_cnt #(
    .CNT_W(CNT_W)
  ) u_cnt (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(cnt_load),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  // A request is taken only in the idle state; outside it the request waits
  // unchanged while req_ready stays low, which is how the host sees a refusal.
  function [1:0] fn_take;
    input idle;
    input valid;
    input write;
    begin
      fn_take = {idle & valid & write, idle & valid & ~write};
    end
  endfunction

  wire [1:0] take;
  wire take_wr;
  wire take_rd;

  assign req_ready = (state_r == ST_IDLE);
  assign take = fn_take(req_ready, req_valid, req_write);
  assign take_wr = take[1];
  assign take_rd = take[0];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_load = 1'b0;
    cnt_val = {CNT_W{1'b0}};
    case (state_r)
      ST_IDLE: begin
        if (take_wr) begin
          state_nxt = ST_WR_SETUP;
        end else if (take_rd) begin
          cnt_load = 1'b1;
          cnt_val = fn_cnt(RD_LOAD);
          state_nxt = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        cnt_load = 1'b1;
        cnt_val = fn_cnt(STROBE_LOAD);
        state_nxt = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          cnt_val = fn_cnt(RECOV_LOAD);
          state_nxt = ST_WR_RECOV;
        end
      end
      ST_WR_RECOV: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Pin and answer registers
  // ----------------------------------------
  // Address and data are set one cycle before the strobe falls and held one
  // cycle after it rises, which costs a cycle but gives margin on both sides.
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      addr_line <= {ADDR_W{1'b0}};
      chip_sel_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      data_line_out <= {DATA_W{1'b0}};
      data_line_oe_n <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= {DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      rd_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          chip_sel_n <= 1'b1;
          data_line_oe_n <= 1'b1;
          // Address and select go out together for reads and writes alike.
          if (take_rd || take_wr) begin
            addr_line <= req_addr;
            chip_sel_n <= 1'b0;
            wr_strobe_n <= 1'b1;
            if (take_wr) begin
              data_line_out <= req_wdata;
              data_line_oe_n <= 1'b0;
            end
          end
        end
        ST_RD_WAIT: begin
          // Sampling here leaves one cycle of margin past the access time.
          if (cnt_done) begin
            rd_data <= data_line_in;
            rd_valid <= 1'b1;
            chip_sel_n <= 1'b1;
          end
        end
        ST_WR_SETUP: begin
          wr_strobe_n <= 1'b0;
        end
        ST_WR_PULSE: begin
          if (cnt_done) begin
            // Strobe ends the write; select stays low so timing refers to it.
            wr_strobe_n <= 1'b1;
          end
        end
        ST_WR_RECOV: begin
          // Select and data drivers let go one cycle after the strobe rises,
          // which gives the write its address and data hold.
          chip_sel_n <= 1'b1;
          data_line_oe_n <= 1'b1;
        end
        default: begin
          chip_sel_n <= 1'b1;
          wr_strobe_n <= 1'b1;
          data_line_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// >>> asr4k_defines.vh
// Timing and geometry constants for the asynchronous static memory host controller.
`ifndef ASR4K_DEFINES_VH
`define ASR4K_DEFINES_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ASR4K_ADDR_W 12
`define ASR4K_DATA_W 4
`define ASR4K_DEPTH 4096

// ----------------------------------------
// Clock and device timing, in ns
// ----------------------------------------
`define ASR4K_CLK_PERIOD_NS 4
`define ASR4K_READ_PERIOD_NS 20
`define ASR4K_ADDR_TO_VALID_DELAY_NS 20
`define ASR4K_CE_TO_VALID_NS 20
`define ASR4K_WRITE_PERIOD_NS 20
`define ASR4K_STROBE_LOW_WIDTH_NS 15
`define ASR4K_CE_TO_WRITE_END_NS 15
`define ASR4K_ADDR_SETUP_END_NS 15
`define ASR4K_DATA_SETUP_NS 10
`define ASR4K_POWER_DOWN_NS 20

// ----------------------------------------
// Derived cycle counts; least times round up
// ----------------------------------------
`define ASR4K_CYC_UP(ns) (((ns) + `ASR4K_CLK_PERIOD_NS - 1) / `ASR4K_CLK_PERIOD_NS)
`define ASR4K_READ_WAIT_CYC `ASR4K_CYC_UP(`ASR4K_ADDR_TO_VALID_DELAY_NS)
`define ASR4K_STROBE_CYC `ASR4K_CYC_UP(`ASR4K_STROBE_LOW_WIDTH_NS)
`define ASR4K_WRITE_CYC `ASR4K_CYC_UP(`ASR4K_WRITE_PERIOD_NS)
`define ASR4K_DATA_SETUP_CYC `ASR4K_CYC_UP(`ASR4K_DATA_SETUP_NS)

`endif

// >>> asr4k_wait_cnt.v
// Loadable down counter that times the read wait, strobe and recovery phases of a memory access.
`timescale 1ns/1ps
module asr4k_wait_cnt #(
  parameter CNT_W = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Control
  input wire load,
  input wire [CNT_W-1:0] load_val,
  // Status
  output wire done
);
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != {CNT_W{1'b0}}) begin
      cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done ignores load, so a caller may load on done without a combinational loop.
  assign done = (cnt_r == {CNT_W{1'b0}});
endmodule

// >>> asr4k_props.sv
// Port checks for the memory host controller.
`timescale 1ns/1ps
module asr4k_chk (
  input wire ref_clk, srst, req_valid, req_write, req_ready, rd_valid,
  input wire chip_sel_n, wr_strobe_n, data_line_oe_n,
  input wire [11:0] req_addr, addr_line,
  input wire [3:0] req_wdata, rd_data, data_line_in, data_line_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire tk_rd = req_valid && req_ready && !req_write;
  wire tk_wr = req_valid && req_ready && req_write;
  property p_rd_lat; tk_rd |=> !rd_valid [*6] ##1 rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");
  property p_rd_cs; tk_rd |=> !chip_sel_n [*5]; endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("select short");
  property p_rd_oe; tk_rd |=> data_line_oe_n [*5]; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("bus driven in read");
  property p_rd_dat; rd_valid |-> rd_data == $past(data_line_in); endproperty
  a_rd_dat: assert property (p_rd_dat) else $error("read data wrong");
  property p_pwe; $fell(wr_strobe_n) |-> !wr_strobe_n [*4]; endproperty
  a_pwe: assert property (p_pwe) else $error("strobe short");
  property p_start; $fell(wr_strobe_n) |-> !chip_sel_n && $stable(addr_line); endproperty
  a_start: assert property (p_start) else $error("write start bad");
  // Strobe ends the write, so select, data and address must outlast it.
  property p_end;
    $rose(wr_strobe_n) |-> !chip_sel_n && !data_line_oe_n && $stable(addr_line)
      && $stable(data_line_out);
  endproperty
  a_end: assert property (p_end) else $error("write end bad");
  property p_sd;
    $rose(wr_strobe_n) |-> !$past(data_line_oe_n, 3)
      && data_line_out == $past(data_line_out, 3);
  endproperty
  a_sd: assert property (p_sd) else $error("data setup short");
  property p_oe; chip_sel_n |-> data_line_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("bus driven idle");
  property p_gap; tk_wr |=> !req_ready [*6] ##1 req_ready; endproperty
  a_gap: assert property (p_gap) else $error("write spacing wrong");
  c_rd: cover property (tk_rd);
  c_wr: cover property (tk_wr);
  c_end: cover property ($rose(wr_strobe_n));
endmodule

// >>> asr4k_mem.sv
// Behavioural model of the 4096 by 4 asynchronous static memory.
`timescale 1ns/1ps
module asr4k_mem (
  input wire [11:0] addr_line,
  input wire chip_sel_n,
  input wire wr_strobe_n,
  input wire [3:0] bus,
  output wire [3:0] q,
  output wire q_en
);
  reg [3:0] mem [0:4095];
  wire wr_n = chip_sel_n | wr_strobe_n;
  always @(posedge wr_n) begin
    mem[addr_line] <= bus;
  end
  // Inertial delays: old data holds until the full access time has run.
  assign #20 q = mem[addr_line];
  assign #5 q_en = !chip_sel_n & wr_strobe_n;
endmodule

// >>> asr4k_ctrl_tb_top.sv
// Self-checking bench for the memory host controller.
`timescale 1ns/1ps
module asr4k_ctrl_tb_top;
  reg ref_clk = 0, srst = 1, req_valid = 0, req_write = 0;
  reg [11:0] req_addr = 12'h000;
  reg [3:0] req_wdata = 4'h0;
  wire req_ready, rd_valid, chip_sel_n, wr_strobe_n, data_line_oe_n, q_en;
  wire [3:0] rd_data, data_line_out, q;
  wire [11:0] addr_line;
  integer miscompares = 0, comparisons = 0, cyc = 0, i, n;
  reg [16:0] rows [0:7];
  // Released lines show a changing pattern so stale data cannot pass.
  wire [3:0] bus = !data_line_oe_n ? data_line_out : q_en ? q : cyc[3:0];
  asr4k_ctrl i_asr4k_ctrl (.ref_clk, .srst, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .rd_valid, .rd_data, .addr_line, .chip_sel_n,
    .wr_strobe_n, .data_line_in(bus), .data_line_out, .data_line_oe_n);
  asr4k_mem i_asr4k_mem (.addr_line, .chip_sel_n, .wr_strobe_n, .bus, .q, .q_en);
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task op(input [16:0] r);
    begin
      @(negedge ref_clk);
      {req_write, req_addr, req_wdata} = r;
      req_valid = 1;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      @(negedge ref_clk);
      req_valid = 0;
    end
  endtask
  task rd_wait(input [3:0] exp);
    begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 20) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk({15'h0000, rd_valid}, 16'h0001);
      chk({12'h000, rd_data}, {12'h000, exp});
    end
  endtask
  initial begin
    rows[0] = {1'b1, 12'h000, 4'h5};
    rows[1] = {1'b1, 12'hFFF, 4'hA};
    rows[2] = {1'b1, 12'h7A3, 4'hC};
    rows[3] = {1'b0, 12'h000, 4'h5};
    rows[4] = {1'b0, 12'hFFF, 4'hA};
    rows[5] = {1'b0, 12'h7A3, 4'hC};
    rows[6] = {1'b1, 12'h000, 4'h3};
    rows[7] = {1'b0, 12'h000, 4'h3};
    repeat (5) @(negedge ref_clk);
    chk({chip_sel_n, wr_strobe_n, data_line_oe_n, rd_valid, addr_line}, 16'hE000);
    srst = 0;
    for (i = 0; i < 8; i = i + 1) begin
      op(rows[i]);
      if (rows[i][16]) chk({15'h0000, req_ready}, 16'h0000);
      else rd_wait(rows[i][3:0]);
      $display("test %0d done", i);
    end
    op({1'b1, 12'h800, 4'hF});
    srst = 1;
    @(negedge ref_clk);
    chk({chip_sel_n, wr_strobe_n, data_line_oe_n, rd_valid, addr_line}, 16'hE000);
    srst = 0;
    op({1'b1, 12'h800, 4'h9});
    op({1'b0, 12'h800, 4'h0});
    rd_wait(4'h9);
    $display("test reset done");
    summarize;
  end
endmodule
bind asr4k_ctrl asr4k_chk i_asr4k_chk (.ref_clk, .srst, .req_valid, .req_write,
  .req_ready, .rd_valid, .chip_sel_n, .wr_strobe_n, .data_line_oe_n, .req_addr,
  .addr_line, .req_wdata, .rd_data, .data_line_in, .data_line_out);
